// ### verilog/p34_pkg.sv
// package for the port 3 / port 4 alternate function multiplexer
// assumes an apb3 slave with 32-bit data and word-indexed registers
package p34_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] P3_DATA_IDX  = 16'hffc4;
  localparam logic [15:0] P3_DIR_IDX   = 16'hffc6;
  localparam logic [15:0] P4_DATA_IDX  = 16'hffc8;
  localparam logic [15:0] P4_DIR_IDX   = 16'hffca;
  localparam logic [15:0] SYSCFG_IDX   = 16'hff00;
  localparam logic [15:0] RSTCFG_IDX   = 16'hff01;

  localparam int          ADDR_W       = 18;
  localparam int          P3_W         = 16;
  localparam int          P4_W         = 8;

  // reset values and port 3 write mask
  localparam logic [15:0] P3_DATA_RST  = 16'h0000;
  localparam logic [15:0] P3_DIR_RST   = 16'h0000;
  localparam logic [7:0]  P4_DATA_RST  = 8'h00;
  localparam logic [7:0]  P4_DIR_RST   = 8'h00;
  localparam logic [15:0] P3_WR_MASK   = 16'hbfff;

  // fixed port 3 line positions
  localparam int          LN_TIMER_SIX_TOGGLE_OUT     = 1;
  localparam int          LN_CAPTURE_INPUT     = 2;
  localparam int          LN_TIMER_THREE_TOGGLE_OUT     = 3;
  localparam int          LN_T3UD      = 4;
  localparam int          LN_TIMER_FOUR_COUNT_IN      = 5;
  localparam int          LN_TIMER_THREE_COUNT_IN      = 6;
  localparam int          LN_TIMER_TWO_COUNT_IN      = 7;
  localparam int          LN_TXD       = 10;
  localparam int          LN_RXD       = 11;
  localparam int          LN_STROBE    = 12;
  localparam int          LN_NOPIN     = 14;
  localparam int          LN_SYSTEM_CLOCK_OUTPUT    = 15;

  // segment line select codes
  localparam logic [1:0]  SEG_64K      = 2'h1;
  localparam logic [1:0]  SEG_256K     = 2'h3;
  localparam logic [1:0]  SEG_1M       = 2'h0;
  localparam logic [1:0]  SEG_16M      = 2'h2;

  // system configuration bits
  typedef struct packed {
    logic system_clock_output_en;
    logic write_config_select;
    logic byte_high_disable;
    logic sync_port_enable;
  } p34_syscfg_t;

  localparam p34_syscfg_t SYSCFG_RST   = '{1'b0, 1'b1, 1'b0, 1'b0};

  // reset strap capture
  typedef struct packed {
    logic       strobe_is_wrh;
    logic [1:0] segment_line_select;
  } p34_strap_t;

  // synchronous serial port signals toward port 4
  typedef struct packed {
    logic clk;
    logic dat_out;
    logic dat_oe;
    logic ce0;
    logic ce1;
  } p34_ssp_t;

endpackage

// ### verilog/p34_mux.sv
// port 3 and port 4 pin multiplexer with apb register access
// assumes peripherals on one side, pad cells with active-low enables on
// the other; all inputs synchronous to mclk_i
//
// Functional notes
// - alternate inputs read the port 3 or port 4 input latch, not the output latch.
// - port 3 alternate output pin value is peripheral output AND latch bit, except the line 12 strobe, which bypasses the latch.
// - direction input leaves pin high-impedance; latch zero holds pin low.
// - unused alternate output lines rest high into the AND gate.
// - serial receive pin is input or output per mode and direction.
// - clock output enable turns on line 15 driver without direction bit.
// - after reset line 12 drives the strap-selected strobe automatically.
// - line 12 reverts to I/O on byte disable one (bhe strap) or write config zero (wrh strap).
// - sync port disabled means all non-segment port 4 lines are direction-driven I/O.
// - sync port enabled outside 16 MB mode takes upper four port 4 pins, ignoring registers.
// - port 4 direction zero is high-impedance input, one is driven output.
// - during external bus cycles selected port 4 pins output segment bits.
// - segment function is active straight from reset when selected.
// - segment line count latched at reset, readable in reset config.
// - select 01 none, 11 two lines, 00 four lines, 10 eight lines.
// - outside 16 MB mode lines 4-7 are I/O or sync port pins.
// - line 10 transmit, 11 receive, lines 1-7 timer signals.
// - port 3 direction zero is high-impedance input, one is output.
`timescale 1ns/1ps

module p34_mux (
  input  wire logic                       mclk_i,      // cpu clock
  input  wire logic                       nrst_i,      // sync reset
  input  wire logic                       ce_i,        // clock enable
  // apb slave
  input  wire logic                       psel_i,      // select
  input  wire logic                       penable_i,   // access phase
  input  wire logic                       pwrite_i,    // write
  input  wire logic [p34_pkg::ADDR_W-1:0] paddr_i,     // byte address
  input  wire logic [31:0]                pwdata_i,    // write data
  output logic      [31:0]                prdata_o,    // read data
  output logic                            pready_o,    // transfer done
  output logic                            pslverr_o,   // unmapped
  // reset strap
  input  wire logic [2:0]                 strap_i,     // wrh, seg sel
  // peripheral side
  input  wire logic                       t6_out_i,    // timer 6 toggle
  input  wire logic                       t3_out_i,    // timer 3 toggle
  input  wire logic                       txd_i,       // serial transmit
  input  wire logic                       rxd_out_i,   // serial rx as out
  input  wire logic                       sysclk_i,    // clock to export
  input  wire logic                       strobe_i,    // bhe or wrh level
  input  wire logic                       bus_cycle_i, // ext bus cycle
  input  wire logic [7:0]                 seg_addr_i,  // a23..a16
  input  wire logic                       ssp_clk_i,   // sync port clock
  input  wire logic                       ssp_dat_i,   // sync data out
  input  wire logic                       ssp_dat_oe_i,// sync data drive
  input  wire logic                       ssp_ce0_i,   // chip enable 0
  input  wire logic                       ssp_ce1_i,   // chip enable 1
  output logic                            capture_input_o,       // capture_input
  output logic                            timer_three_updown_in_o, // ud
  output logic                            timer_four_count_in_o, // t4
  output logic                            timer_three_count_in_o,// t3
  output logic                            timer_two_count_in_o,  // t2
  output logic                            serial_receive_o,      // rxd
  output logic                            sync_port_data_o,      // ssp in
  // pin side
  input  wire logic [15:0]                p3_in_i,     // port 3 pins
  output logic      [15:0]                p3_out_o,    // port 3 drive
  output logic      [15:0]                p3_oe_n_o,   // low drives
  input  wire logic [7:0]                 p4_in_i,     // port 4 pins
  output logic      [7:0]                 p4_out_o,    // port 4 drive
  output logic      [7:0]                 p4_oe_n_o    // low drives
);

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  function automatic logic [7:0] seg_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    case (sel)
      p34_pkg::SEG_256K: m = 8'h03;
      p34_pkg::SEG_1M:   m = 8'h0f;
      p34_pkg::SEG_16M:  m = 8'hff;
      default:           m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] reg_idx(
    input logic [p34_pkg::ADDR_W-1:0] a);
    return a[p34_pkg::ADDR_W-1:2];
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [15:0]          p3_data_ff;
  logic [15:0]          nxt_p3_data;
  logic [15:0]          p3_dir_ff;
  logic [15:0]          nxt_p3_dir;
  logic [7:0]           p4_data_ff;
  logic [7:0]           nxt_p4_data;
  logic [7:0]           p4_dir_ff;
  logic [7:0]           nxt_p4_dir;
  p34_pkg::p34_syscfg_t syscfg_ff;
  p34_pkg::p34_syscfg_t nxt_syscfg;
  p34_pkg::p34_strap_t  strap_ff;
  p34_pkg::p34_strap_t  nxt_strap;
  logic [31:0]          nxt_prdata;
  logic                 nxt_pready;
  logic                 nxt_pslverr;
  logic                 wr_en;
  logic                 hit;
  logic [15:0]          idx;

  // --------------------------------------------------------------
  // apb slave: one wait state, write at the pready edge
  // --------------------------------------------------------------
  always_comb
  begin
    idx         = reg_idx(paddr_i);
    nxt_p3_data = p3_data_ff;
    nxt_p3_dir  = p3_dir_ff;
    nxt_p4_data = p4_data_ff;
    nxt_p4_dir  = p4_dir_ff;
    nxt_syscfg  = syscfg_ff;
    nxt_pready  = psel_i && penable_i && !pready_o;
    nxt_prdata  = prdata_o;
    hit         = 1'b1;
    wr_en       = psel_i && penable_i && pready_o && pwrite_i;
    case (idx)
      p34_pkg::P3_DATA_IDX: nxt_prdata = {16'h0000, p3_data_ff};
      p34_pkg::P3_DIR_IDX:  nxt_prdata = {16'h0000, p3_dir_ff};
      p34_pkg::P4_DATA_IDX: nxt_prdata = {24'h000000, p4_data_ff};
      p34_pkg::P4_DIR_IDX:  nxt_prdata = {24'h000000, p4_dir_ff};
      p34_pkg::SYSCFG_IDX:  nxt_prdata = {28'h0000000, syscfg_ff};
      p34_pkg::RSTCFG_IDX:  nxt_prdata = {29'h00000000, strap_ff};
      default:
      begin
        nxt_prdata = 32'h00000000;
        hit        = 1'b0;
      end
    endcase
    if (!nxt_pready || pwrite_i)
      nxt_prdata = 32'h00000000;
    nxt_pslverr = nxt_pready && !hit;
    if (wr_en)
    begin
      case (idx)
        p34_pkg::P3_DATA_IDX:
          nxt_p3_data = pwdata_i[15:0] & p34_pkg::P3_WR_MASK;
        p34_pkg::P3_DIR_IDX:
          nxt_p3_dir  = pwdata_i[15:0] & p34_pkg::P3_WR_MASK;
        p34_pkg::P4_DATA_IDX: nxt_p4_data = pwdata_i[7:0];
        p34_pkg::P4_DIR_IDX:  nxt_p4_dir  = pwdata_i[7:0];
        p34_pkg::SYSCFG_IDX:  nxt_syscfg  = pwdata_i[3:0];
        default:              nxt_syscfg  = syscfg_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      p3_data_ff <= p34_pkg::P3_DATA_RST;
      p3_dir_ff  <= p34_pkg::P3_DIR_RST;
      p4_data_ff <= p34_pkg::P4_DATA_RST;
      p4_dir_ff  <= p34_pkg::P4_DIR_RST;
      syscfg_ff  <= p34_pkg::SYSCFG_RST;
      prdata_o   <= 32'h00000000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      p3_data_ff <= nxt_p3_data;
      p3_dir_ff  <= nxt_p3_dir;
      p4_data_ff <= nxt_p4_data;
      p4_dir_ff  <= nxt_p4_dir;
      syscfg_ff  <= nxt_syscfg;
      prdata_o   <= nxt_prdata;
      pready_o   <= nxt_pready;
      pslverr_o  <= nxt_pslverr;
    end
  end

  // --------------------------------------------------------------
  // strap capture while reset is held
  // --------------------------------------------------------------
  always_comb
  begin
    nxt_strap = strap_ff;
    if (!nrst_i)
      nxt_strap = strap_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
      strap_ff <= nxt_strap;
  end

  // --------------------------------------------------------------
  // port 3 pin multiplexing
  // --------------------------------------------------------------
  logic [15:0] alt_out;
  logic [15:0] nxt_p3_out;
  logic [15:0] nxt_p3_oe_n;
  logic        strobe_on;

  always_comb
  begin
    alt_out                      = 16'hffff;
    alt_out[p34_pkg::LN_TIMER_SIX_TOGGLE_OUT]   = t6_out_i;
    alt_out[p34_pkg::LN_TIMER_THREE_TOGGLE_OUT]   = t3_out_i;
    alt_out[p34_pkg::LN_TXD]     = txd_i;
    alt_out[p34_pkg::LN_RXD]     = rxd_out_i;
    alt_out[p34_pkg::LN_SYSTEM_CLOCK_OUTPUT]  = syscfg_ff.system_clock_output_en ? sysclk_i : 1'b1;
    nxt_p3_out                   = p3_data_ff & alt_out;
    nxt_p3_oe_n                  = ~p3_dir_ff;
    strobe_on = strap_ff.strobe_is_wrh ?
                syscfg_ff.write_config_select :
                !syscfg_ff.byte_high_disable;
    if (syscfg_ff.system_clock_output_en)
      nxt_p3_oe_n[p34_pkg::LN_SYSTEM_CLOCK_OUTPUT] = 1'b0;
    if (strobe_on)
    begin
      nxt_p3_out[p34_pkg::LN_STROBE]  = strobe_i;
      nxt_p3_oe_n[p34_pkg::LN_STROBE] = 1'b0;
    end
    nxt_p3_oe_n[p34_pkg::LN_NOPIN] = 1'b1;
  end

  // --------------------------------------------------------------
  // port 4 pin multiplexing
  // --------------------------------------------------------------
  logic [7:0] smask;
  logic [7:0] nxt_p4_out;
  logic [7:0] nxt_p4_oe_n;
  logic       ssp_on;

  always_comb
  begin
    smask       = seg_mask(strap_ff.segment_line_select);
    ssp_on      = syscfg_ff.sync_port_enable &&
                  strap_ff.segment_line_select != p34_pkg::SEG_16M;
    nxt_p4_out  = p4_data_ff;
    nxt_p4_oe_n = ~p4_dir_ff;
    if (ssp_on)
    begin
      nxt_p4_out[4]  = ssp_ce1_i;
      nxt_p4_out[5]  = ssp_ce0_i;
      nxt_p4_out[6]  = ssp_dat_i;
      nxt_p4_out[7]  = ssp_clk_i;
      nxt_p4_oe_n[4] = 1'b0;
      nxt_p4_oe_n[5] = 1'b0;
      nxt_p4_oe_n[6] = !ssp_dat_oe_i;
      nxt_p4_oe_n[7] = 1'b0;
    end
    for (int i = 0; i < p34_pkg::P4_W; i++)
    begin
      if (smask[i])
      begin
        // hold the last segment between bus cycles
        nxt_p4_out[i]  = bus_cycle_i ? seg_addr_i[i] : p4_out_o[i];
        nxt_p4_oe_n[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      p3_out_o  <= 16'h0000;
      p3_oe_n_o <= 16'hffff;
      p4_out_o  <= 8'h00;
      p4_oe_n_o <= 8'hff;
    end
    else if (ce_i)
    begin
      p3_out_o  <= nxt_p3_out;
      p3_oe_n_o <= nxt_p3_oe_n;
      p4_out_o  <= nxt_p4_out;
      p4_oe_n_o <= nxt_p4_oe_n;
    end
  end

  // --------------------------------------------------------------
  // input latches and alternate inputs
  // --------------------------------------------------------------
  logic [15:0] p3_in_ff;
  logic        p4_dat_in_ff;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      p3_in_ff                <= 16'h0000;
      p4_dat_in_ff            <= 1'b0;
      capture_input_o         <= 1'b0;
      timer_three_updown_in_o <= 1'b0;
      timer_four_count_in_o   <= 1'b0;
      timer_three_count_in_o  <= 1'b0;
      timer_two_count_in_o    <= 1'b0;
      serial_receive_o        <= 1'b0;
      sync_port_data_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      p3_in_ff                <= p3_in_i;
      p4_dat_in_ff            <= p4_in_i[6];
      capture_input_o         <= p3_in_ff[p34_pkg::LN_CAPTURE_INPUT];
      timer_three_updown_in_o <= p3_in_ff[p34_pkg::LN_T3UD];
      timer_four_count_in_o   <= p3_in_ff[p34_pkg::LN_TIMER_FOUR_COUNT_IN];
      timer_three_count_in_o  <= p3_in_ff[p34_pkg::LN_TIMER_THREE_COUNT_IN];
      timer_two_count_in_o    <= p3_in_ff[p34_pkg::LN_TIMER_TWO_COUNT_IN];
      serial_receive_o        <= p3_in_ff[p34_pkg::LN_RXD];
      sync_port_data_o        <= p4_dat_in_ff;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_P3_AND_LATCH: assert property (
    ce_i && !p3_data_ff[p34_pkg::LN_TXD] |=> !p3_out_o[p34_pkg::LN_TXD])
    else $error("transmit pin high while latch bit is zero");

  AST_P3_INPUT_HIZ: assert property (
    ce_i && !p3_dir_ff[p34_pkg::LN_TIMER_THREE_TOGGLE_OUT]
    |=> p3_oe_n_o[p34_pkg::LN_TIMER_THREE_TOGGLE_OUT])
    else $error("port 3 line driven while direction is input");

  AST_SYSTEM_CLOCK_OUTPUT_DRV: assert property (
    ce_i && syscfg_ff.system_clock_output_en && !p3_dir_ff[p34_pkg::LN_SYSTEM_CLOCK_OUTPUT]
    |=> !p3_oe_n_o[p34_pkg::LN_SYSTEM_CLOCK_OUTPUT])
    else $error("clock output driver not enabled");

  AST_STROBE_OUT: assert property (
    ce_i && strobe_on |=> !p3_oe_n_o[p34_pkg::LN_STROBE]
    && p3_out_o[p34_pkg::LN_STROBE] == $past(strobe_i))
    else $error("strobe not on line 12");

  AST_STROBE_OFF: assert property (
    ce_i && !strap_ff.strobe_is_wrh && syscfg_ff.byte_high_disable
    |=> p3_oe_n_o[p34_pkg::LN_STROBE] == $past(~p3_dir_ff[12]))
    else $error("line 12 not returned to general use");

  AST_P4_GPIO: assert property (
    ce_i && !syscfg_ff.sync_port_enable
    && strap_ff.segment_line_select == p34_pkg::SEG_64K
    |=> p4_oe_n_o == ~$past(p4_dir_ff) && p4_out_o == $past(p4_data_ff))
    else $error("port 4 not under its registers");

  AST_SSP_CLK: assert property (
    ce_i && ssp_on |=> p4_out_o[7] == $past(ssp_clk_i) && !p4_oe_n_o[7])
    else $error("sync port clock not on line 7");

  AST_SEG_ADDR: assert property (
    ce_i && bus_cycle_i
    && strap_ff.segment_line_select == p34_pkg::SEG_16M
    |=> p4_out_o == $past(seg_addr_i) && p4_oe_n_o == 8'h00)
    else $error("segment address not on port 4");

  AST_ALT_INPUT: assert property (
    ce_i [*2] |=> timer_two_count_in_o == $past(p3_in_i[7], 2))
    else $error("timer input not from pin latch");

  AST_P4_UPPER_ZERO: assert property (
    pready_o && reg_idx(paddr_i) == p34_pkg::P4_DIR_IDX
    |-> prdata_o[31:8] == 24'h000000)
    else $error("port 4 upper bits not zero");

  COV_SSP_ON: cover property (ce_i && ssp_on);
  COV_SEG_16M: cover property (
    ce_i && bus_cycle_i
    && strap_ff.segment_line_select == p34_pkg::SEG_16M);
  COV_SYSTEM_CLOCK_OUTPUT: cover property (ce_i && syscfg_ff.system_clock_output_en);
  COV_APB_WRITE: cover property (wr_en && ce_i);

endmodule

// ### sim/p34_far_model.sv
// far side of the pads: resolves port 3 and port 4 pin levels
// assumes active-low drive enables from the mux, levels set by the bench
`timescale 1ns/1ps

module p34_far_model (
  input  wire logic [15:0] p3_o_i,   // mux drive, port 3
  input  wire logic [15:0] p3_n_i,   // low when mux drives
  input  wire logic [15:0] p3_x_i,   // outside level, port 3
  input  wire logic [7:0]  p4_o_i,   // mux drive, port 4
  input  wire logic [7:0]  p4_n_i,   // low when mux drives
  input  wire logic [7:0]  p4_x_i,   // outside level, port 4
  output logic      [15:0] p3_pin_o, // pin level, port 3
  output logic      [7:0]  p4_pin_o  // pin level, port 4
);
  // -----------------------------------------------------------
  // pad resolution
  // -----------------------------------------------------------
  // outside parts drive only the lines that the mux has released
  assign p3_pin_o = (~p3_n_i & p3_o_i) | (p3_n_i & p3_x_i);
  assign p4_pin_o = (~p4_n_i & p4_o_i) | (p4_n_i & p4_x_i);
endmodule

// ### sim/test_port3_port4_alt_function_mux.sv
// self-checking bench for the port 3 / port 4 multiplexer
// assumes p34_pkg, p34_mux and p34_far_model are compiled first
`timescale 1ns/1ps

module test_port3_port4_alt_function_mux;
  logic                 mclk_i, nrst_i, ce_i, psel, pen, pwr;
  logic                 pready, pslverr;
  logic [17:0]          paddr;
  logic [31:0]          pwdata, prdata, r;
  logic [2:0]           strap;
  logic [11:0]          pv;
  logic [6:0]           ai;
  logic [7:0]           seg, p4i, p4o, p4n, x4, m4d, m4r, hold;
  logic [7:0]           e4o, e4n, msk, p4v;
  logic [15:0]          p3i, p3o, p3n, x3, m3d, m3r, e3o, e3n, p3v;
  p34_pkg::p34_syscfg_t sys;
  logic [32:0]          q[$];
  int                   errors, n_compared;

  p34_mux i_p34_mux (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .strap_i(strap), .t6_out_i(pv[11]), .t3_out_i(pv[10]), .txd_i(pv[9]),
    .rxd_out_i(pv[8]), .sysclk_i(pv[7]), .strobe_i(pv[6]),
    .bus_cycle_i(pv[5]), .seg_addr_i(seg), .ssp_clk_i(pv[4]),
    .ssp_dat_i(pv[3]), .ssp_dat_oe_i(pv[2]), .ssp_ce0_i(pv[1]),
    .ssp_ce1_i(pv[0]), .capture_input_o(ai[6]),
    .timer_three_updown_in_o(ai[5]), .timer_four_count_in_o(ai[4]),
    .timer_three_count_in_o(ai[3]), .timer_two_count_in_o(ai[2]),
    .serial_receive_o(ai[1]), .sync_port_data_o(ai[0]), .p3_in_i(p3i),
    .p3_out_o(p3o), .p3_oe_n_o(p3n), .p4_in_i(p4i), .p4_out_o(p4o),
    .p4_oe_n_o(p4n));

  p34_far_model i_p34_far_model (
    .p3_o_i(p3o), .p3_n_i(p3n), .p3_x_i(x3), .p4_o_i(p4o),
    .p4_n_i(p4n), .p4_x_i(x4), .p3_pin_o(p3i), .p4_pin_o(p4i));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // -----------------------------------------------------------
  // checking
  // -----------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    n_compared++;
    if (got !== ex)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic cmp_bus(input logic [32:0] ex);
    n_compared++;
    if ({pslverr, prdata} !== ex)
    begin
      errors++;
      $display("[ERR] apb exp %h got %h", ex, {pslverr, prdata});
    end
  endtask

  // answer cycle: oldest note against error flag and read data
  always @(posedge mclk_i)
    if (pready === 1'b1)
      cmp_bus(q.size() > 0 ? q.pop_front() : 33'h1_ffff_ffff);

  // -----------------------------------------------------------
  // apb master
  // -----------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] ix,
                     input logic [31:0] wd, input logic [32:0] ex);
    int k;
    k = 0;
    @(posedge mclk_i);
    q.push_back(ex);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge mclk_i);
    pen <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      final_report();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] ix, input logic [31:0] v);
    apb(1'b0, ix, 32'h0, {1'b0, v});
  endtask

  // -----------------------------------------------------------
  // expected pad state
  // -----------------------------------------------------------
  task automatic predict();
    logic [15:0] alt;
    logic        en;
    alt = 16'hffff;
    alt[1] = pv[11];
    alt[3] = pv[10];
    alt[10] = pv[9];
    alt[11] = pv[8];
    alt[15] = sys.system_clock_output_en ? pv[7] : 1'b1;
    e3o = m3d & alt;
    e3n = ~m3r;
    e3n[14] = 1'b1;
    e3n[15] = ~(m3r[15] | sys.system_clock_output_en);
    en = strap[2] ? sys.write_config_select : ~sys.byte_high_disable;
    if (en)
    begin
      e3o[12] = pv[6];
      e3n[12] = 1'b0;
    end
    case (strap[1:0])
      p34_pkg::SEG_64K:  msk = 8'h00;
      p34_pkg::SEG_256K: msk = 8'h03;
      p34_pkg::SEG_1M:   msk = 8'h0f;
      default:           msk = 8'hff;
    endcase
    e4o = m4d;
    e4n = ~m4r;
    if (sys.sync_port_enable)
    begin
      e4o[7:4] = {pv[4], pv[3], pv[1], pv[0]};
      e4n[7:4] = {1'b0, ~pv[2], 2'b00};
    end
    e4o = (e4o & ~msk) | (hold & msk);
    e4n = e4n & ~msk;
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial
  begin
    ce_i = 1'b1;
    nrst_i = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    strap = '0;
    pv = '1;
    seg = '0;
    x3 = '0;
    x4 = '0;
    hold = '0;
    errors = 0;
    n_compared = 0;
    void'($urandom(75811));
    for (int c = 0; c < 4; c++)
    begin
      r = $urandom();
      nrst_i <= 1'b0;
      strap <= {r[12], 2'(c)};
      pv <= r[11:0];
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      {m3d, m3r, m4d, m4r} = '0;
      sys = p34_pkg::SYSCFG_RST;
      repeat (3) @(posedge mclk_i);
      predict();
      chk("p3_oe_n", e3n, p3n);
      chk("p4_oe_n", {8'h0, e4n}, {8'h0, p4n});
      chk("strobe", {15'h0, pv[6]}, {15'h0, p3o[12]});
      rd(p34_pkg::P3_DATA_IDX, 32'h0);
      rd(p34_pkg::P3_DIR_IDX, 32'h0);
      rd(p34_pkg::P4_DATA_IDX, 32'h0);
      rd(p34_pkg::P4_DIR_IDX, 32'h0);
      rd(p34_pkg::SYSCFG_IDX, {28'h0, p34_pkg::SYSCFG_RST});
      rd(p34_pkg::RSTCFG_IDX, {29'h0, strap});
      apb(1'b1, 16'h0123, 32'hffff_ffff, {1'b1, 32'h0});
      apb(1'b0, 16'h0123, 32'h0, {1'b1, 32'h0});
      for (int it = 0; it < 8; it++)
      begin
        r = $urandom();
        pv <= r[11:0] | (it == 0 ? 12'h020 : 12'h000);
        seg <= r[19:12];
        x4 <= r[27:20];
        if (r[5] || it == 0)
          hold = r[19:12];
        x3 <= 16'($urandom());
        r = $urandom();
        m3d = r[15:0] & p34_pkg::P3_WR_MASK;
        m3r = r[31:16] & p34_pkg::P3_WR_MASK;
        apb(1'b1, p34_pkg::P3_DATA_IDX, r, 33'h0);
        apb(1'b1, p34_pkg::P3_DIR_IDX, {r[15:0], r[31:16]}, 33'h0);
        r = $urandom();
        m4d = r[7:0];
        m4r = r[15:8];
        sys = p34_pkg::p34_syscfg_t'(r[19:16]);
        apb(1'b1, p34_pkg::P4_DATA_IDX, r, 33'h0);
        apb(1'b1, p34_pkg::P4_DIR_IDX, {r[23:0], r[15:8]}, 33'h0);
        apb(1'b1, p34_pkg::SYSCFG_IDX, {r[27:0], r[19:16]}, 33'h0);
        apb(1'b1, p34_pkg::RSTCFG_IDX, ~r, 33'h0);
        repeat (3) @(posedge mclk_i);
        predict();
        p3v = (e3o & ~e3n) | (x3 & e3n);
        p4v = (e4o & ~e4n) | (x4 & e4n);
        chk("p3_oe_n", e3n, p3n);
        chk("p3_out", e3o & ~e3n, p3o & ~e3n);
        chk("p4_oe_n", {8'h0, e4n}, {8'h0, p4n});
        chk("p4_out", {8'h0, e4o & ~e4n}, {8'h0, p4o & ~e4n});
        chk("alt_in", {9'h0, p3v[2], p3v[4], p3v[5], p3v[6], p3v[7],
            p3v[11], p4v[6]}, {9'h0, ai});
        rd(p34_pkg::P3_DATA_IDX, {16'h0, m3d});
        rd(p34_pkg::P3_DIR_IDX, {16'h0, m3r});
        rd(p34_pkg::P4_DATA_IDX, {24'h0, m4d});
        rd(p34_pkg::P4_DIR_IDX, {24'h0, m4r});
        rd(p34_pkg::SYSCFG_IDX, {28'h0, sys});
        rd(p34_pkg::RSTCFG_IDX, {29'h0, strap});
        // clock enable low: port 3 driven outputs must keep the state predicted above
        ce_i <= 1'b0;
        pv <= ~pv;
        repeat (3) @(posedge mclk_i);
        chk("ce_hold", e3o & ~e3n, p3o & ~e3n);
        ce_i <= 1'b1;
      end
    end
    repeat (2) @(posedge mclk_i);
    final_report();
  end
endmodule
